// ===== hw/refresh_engine.sv
// internal refresh cycle: row counter and busy time
// assumes start_i is a one-cycle pulse on clk_i
`timescale 1ns/10ps
`default_nettype none
module refresh_engine (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic start_i,
   output logic active_o,
   output logic [sdram_pkg::ROW_W-1:0] row_o,
   output logic idle_o
);
   logic [sdram_pkg::CNT_W-1:0] cnt_reg, cnt_next;
   logic [sdram_pkg::ROW_W-1:0] row_reg, row_next;
   logic active_reg, active_next;
   logic idle_reg, idle_next;

   always_comb begin
      cnt_next = cnt_reg;
      row_next = row_reg;
      if (start_i) begin
         // the address pins never reach here: rows come from this counter
         cnt_next = sdram_pkg::T_RFC_CYC; // R6
         row_next = row_reg + 1'b1; // R6
      end else if (cnt_reg != '0) begin
         cnt_next = cnt_reg - 1'b1;
      end
      active_next = (cnt_next != '0);
      idle_next = !active_next; // R6
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt_reg <= '0;
         row_reg <= '0;
         active_reg <= 1'b0;
         idle_reg <= 1'b1;
      end else begin
         cnt_reg <= cnt_next;
         row_reg <= row_next;
         active_reg <= active_next;
         idle_reg <= idle_next;
      end
   end

   assign active_o = active_reg;
   assign row_o = row_reg;
   assign idle_o = idle_reg;
endmodule // refresh_engine
`default_nettype wire

// ===== hw/sdram_cmd_core.sv
// command decode, write burst capture, refresh and self-refresh control
// assumes ck_i is the controller's command clock, which may stop in
// self-refresh; clk_i is the device's own free-running oscillator
`timescale 1ns/10ps
`default_nettype none
module sdram_cmd_core (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic ck_i,
   input wire sdram_pkg::cmd_pins_t cmd_i,
   input wire logic cke_i,
   input wire logic a12_i,
   input wire logic [sdram_pkg::DQ_W-1:0] dq_i,
   input wire logic [sdram_pkg::DM_W-1:0] dm_i,
   input wire logic strobe_err_i,
   input wire logic dll_disable_i,
   output sdram_pkg::beat_t beat_o,
   output logic beat_valid_o,
   output logic burst_chop_o,
   output logic wr_corrupt_o,
   output logic refresh_active_o,
   output logic [sdram_pkg::ROW_W-1:0] refresh_row_o,
   output logic banks_idle_o,
   output logic self_refresh_o,
   output logic dll_on_o,
   output logic dll_reset_o,
   output logic clk_gate_o
);

   // ------------------------------------------------------------
   // link side: command decode on the command clock
   // ------------------------------------------------------------
   sdram_pkg::link_state_t link_st_reg, link_st_next;
   logic [sdram_pkg::BEAT_W-1:0] beats_reg, beats_next;
   logic cke_prev_reg, cke_prev_next, err_reg, err_next;
   logic ref_tog_reg, ref_tog_next, sr_flag_reg, sr_flag_next;
   sdram_pkg::beat_t beat_reg, beat_next;
   logic beat_valid_reg, beat_valid_next, chop_reg, chop_next;
   logic corrupt_reg, corrupt_next;
   logic cmd_ok, ref_pat, col_cmd, is_wr, is_rd, is_ref, is_sre;

   always_comb begin
      // every command input but cke is ignored while in self-refresh
      cmd_ok = cke_prev_reg && (link_st_reg != sdram_pkg::L_SELF) &&
               !cmd_i.cs_n; // R16
      ref_pat = !cmd_i.ras_n && !cmd_i.cas_n && cmd_i.we_n;
      col_cmd = cmd_ok && cke_i && cmd_i.ras_n && !cmd_i.cas_n;
      is_wr = col_cmd && !cmd_i.we_n;
      is_rd = col_cmd && cmd_i.we_n;
      is_ref = cmd_ok && cke_i && ref_pat;
      is_sre = cmd_ok && !cke_i && ref_pat; // R11
      link_st_next = link_st_reg;
      beats_next = beats_reg;
      cke_prev_next = cke_i;
      err_next = err_reg;
      ref_tog_next = ref_tog_reg;
      sr_flag_next = sr_flag_reg;
      beat_next = beat_reg;
      beat_valid_next = 1'b0;
      chop_next = chop_reg;
      corrupt_next = 1'b0;
      case (link_st_reg)
         sdram_pkg::L_WRITE: begin
            // mask travels with data, one bit per byte lane
            beat_next.data = dq_i; // R3
            beat_next.mask = dm_i; // R3
            beat_valid_next = 1'b1;
            beats_next = beats_reg - 1'b1;
            err_next = err_reg | strobe_err_i; // R2
            if (beats_reg == sdram_pkg::BEAT_LAST) begin
               // a bad strobe only flags this burst; the decoder runs on
               link_st_next = sdram_pkg::L_IDLE; // R2
               corrupt_next = err_reg | strobe_err_i; // R2
               err_next = 1'b0;
            end
         end
         sdram_pkg::L_READ: begin
            // mask pins are not looked at during reads
            beats_next = beats_reg - 1'b1; // R3
            if (beats_reg == sdram_pkg::BEAT_LAST) begin
               link_st_next = sdram_pkg::L_IDLE;
            end
         end
         sdram_pkg::L_SELF: begin
            if (cke_i) begin
               link_st_next = sdram_pkg::L_IDLE; // R14
               sr_flag_next = 1'b0;
            end
         end
         default: begin
            link_st_next = sdram_pkg::L_IDLE;
         end
      endcase
      if (is_wr || is_rd) begin
         // a12 picks the length and is never a column bit
         link_st_next = is_wr ? sdram_pkg::L_WRITE : sdram_pkg::L_READ;
         beats_next = a12_i ? sdram_pkg::BURST_FULL_BEATS :
                      sdram_pkg::BURST_CHOP_BEATS; // R1
         chop_next = !a12_i; // R1
         err_next = 1'b0;
      end
      if (is_ref) begin
         // every refresh is performed, pulled-in ones as well
         ref_tog_next = !ref_tog_reg; // R9
      end
      if (is_sre) begin
         link_st_next = sdram_pkg::L_SELF; // R11
         sr_flag_next = 1'b1;
      end
   end

   always_ff @(posedge ck_i or negedge nrst_i) begin
      if (!nrst_i) begin
         link_st_reg <= sdram_pkg::L_IDLE;
         beats_reg <= '0;
         cke_prev_reg <= 1'b0;
         err_reg <= 1'b0;
         ref_tog_reg <= 1'b0;
         sr_flag_reg <= 1'b0;
         beat_reg <= '0;
         beat_valid_reg <= 1'b0;
         chop_reg <= 1'b0;
         corrupt_reg <= 1'b0;
      end else begin
         link_st_reg <= link_st_next;
         beats_reg <= beats_next;
         cke_prev_reg <= cke_prev_next;
         err_reg <= err_next;
         ref_tog_reg <= ref_tog_next;
         sr_flag_reg <= sr_flag_next;
         beat_reg <= beat_next;
         beat_valid_reg <= beat_valid_next;
         chop_reg <= chop_next;
         corrupt_reg <= corrupt_next;
      end
   end

   assign beat_o = beat_reg;
   assign beat_valid_o = beat_valid_reg;
   assign burst_chop_o = chop_reg;
   assign wr_corrupt_o = corrupt_reg;

   // ------------------------------------------------------------
   // crossing into the internal clock
   // ------------------------------------------------------------
   // cke is taken from the pin, since the command clock may be halted
   logic cke_s, sr_s, ref_s;

   sync3 #(
      .W(3)
   ) u_sync (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .d_i({cke_i, sr_flag_reg, ref_tog_reg}),
      .q_o({cke_s, sr_s, ref_s})
   );

   // ------------------------------------------------------------
   // internal side: refresh scheduling and self-refresh
   // ------------------------------------------------------------
   sdram_pkg::sr_state_t sr_st_reg, sr_st_next;
   logic ref_seen_reg, ref_seen_next, sr_prev_reg, sr_prev_next;
   logic [sdram_pkg::CNT_W-1:0] refi_reg, refi_next;
   logic dll_on_reg, dll_on_next, dll_rst_reg, dll_rst_next;
   logic gate_reg, gate_next, ref_start;

   always_comb begin
      sr_st_next = sr_st_reg;
      ref_seen_next = ref_s;
      sr_prev_next = sr_s;
      refi_next = refi_reg;
      dll_on_next = dll_on_reg;
      dll_rst_next = 1'b0;
      gate_next = gate_reg;
      ref_start = 1'b0;
      case (sr_st_reg)
         sdram_pkg::S_NORMAL: begin
            dll_on_next = !dll_disable_i;
            ref_start = (ref_s != ref_seen_reg); // R6
            if (sr_s && !sr_prev_reg) begin
               // refresh at once so one lands well inside the minimum stay
               sr_st_next = sdram_pkg::S_SELF;
               ref_start = 1'b1; // R17
               refi_next = sdram_pkg::T_REFI_CYC; // R16
               dll_on_next = 1'b0; // R15
               gate_next = 1'b1; // R16
            end
         end
         sdram_pkg::S_SELF: begin
            if (refi_reg == '0) begin
               ref_start = 1'b1; // R16
               refi_next = sdram_pkg::T_REFI_CYC; // R16
            end else begin
               refi_next = refi_reg - 1'b1;
            end
            // waiting for the link side too avoids a stale cke exiting early
            if (cke_s && !sr_s) begin
               sr_st_next = sdram_pkg::S_NORMAL; // R14
               dll_on_next = !dll_disable_i; // R15
               dll_rst_next = !dll_disable_i; // R15
               gate_next = 1'b0; // R16
            end
         end
         default: begin
            sr_st_next = sdram_pkg::S_NORMAL;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sr_st_reg <= sdram_pkg::S_NORMAL;
         ref_seen_reg <= 1'b0;
         sr_prev_reg <= 1'b0;
         refi_reg <= '0;
         dll_on_reg <= 1'b0;
         dll_rst_reg <= 1'b0;
         gate_reg <= 1'b0;
      end else begin
         sr_st_reg <= sr_st_next;
         ref_seen_reg <= ref_seen_next;
         sr_prev_reg <= sr_prev_next;
         refi_reg <= refi_next;
         dll_on_reg <= dll_on_next;
         dll_rst_reg <= dll_rst_next;
         gate_reg <= gate_next;
      end
   end

   refresh_engine u_refresh (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .start_i(ref_start),
      .active_o(refresh_active_o),
      .row_o(refresh_row_o),
      .idle_o(banks_idle_o)
   );

   assign self_refresh_o = gate_reg;
   assign dll_on_o = dll_on_reg;
   assign dll_reset_o = dll_rst_reg;
   assign clk_gate_o = gate_reg;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   logic [sdram_pkg::CNT_W-1:0] gap_reg, gap_next;

   always_comb begin
      gap_next = (gate_reg && !ref_start) ? gap_reg + 1'b1 : '0;
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         gap_reg <= '0;
      end else begin
         gap_reg <= gap_next;
      end
   end

   property p_chop_four;
      @(posedge ck_i) disable iff (!nrst_i)
      (is_wr && !a12_i) ##1 (!col_cmd)[*4] |->
         beat_valid_o && $past(beat_valid_o, 2) ##1 beat_valid_o
         ##1 !beat_valid_o;
   endproperty
   a_chop_four: assert property (p_chop_four) // R1
      else $error("chopped write did not give four beats");

   property p_corrupt_flag;
      @(posedge ck_i) disable iff (!nrst_i)
      (link_st_reg == sdram_pkg::L_WRITE && strobe_err_i && !col_cmd &&
       beats_reg == sdram_pkg::BEAT_LAST) |=> wr_corrupt_o;
   endproperty
   a_corrupt_flag: assert property (p_corrupt_flag) // R2
      else $error("strobe fault not flagged on last beat");

   property p_read_no_beats;
      @(posedge ck_i) disable iff (!nrst_i)
      (is_rd ##1 !col_cmd) |=> !beat_valid_o;
   endproperty
   a_read_no_beats: assert property (p_read_no_beats) // R3
      else $error("beat captured during a read");

   property p_self_hold;
      @(posedge ck_i) disable iff (!nrst_i)
      (link_st_reg == sdram_pkg::L_SELF && !cke_i) |=>
         link_st_reg == sdram_pkg::L_SELF && $stable(ref_tog_reg);
   endproperty
   a_self_hold: assert property (p_self_hold) // R14
      else $error("left self-refresh or took a command with cke low");

   property p_busy_time;
      @(posedge clk_i) disable iff (!nrst_i)
      $rose(refresh_active_o) |-> refresh_active_o[*3] ##1 banks_idle_o
         || refresh_active_o;
   endproperty
   a_busy_time: assert property (p_busy_time) // R6
      else $error("refresh busy time too short");

   property p_row_step;
      @(posedge clk_i) disable iff (!nrst_i)
      $rose(refresh_active_o) |->
         refresh_row_o == $past(refresh_row_o) + 1'b1;
   endproperty
   a_row_step: assert property (p_row_step) // R6
      else $error("internal row counter did not advance");

   property p_entry_refresh;
      @(posedge clk_i) disable iff (!nrst_i)
      $rose(self_refresh_o) |-> ##[0:2] refresh_active_o;
   endproperty
   a_entry_refresh: assert property (p_entry_refresh) // R17
      else $error("no refresh after self-refresh entry");

   property p_dll_exit;
      @(posedge clk_i) disable iff (!nrst_i)
      ($fell(self_refresh_o) && !dll_disable_i) |-> dll_on_o && dll_reset_o
         ##1 !dll_reset_o;
   endproperty
   a_dll_exit: assert property (p_dll_exit) // R15
      else $error("dll not restarted with one reset pulse");

   property p_dll_entry;
      @(posedge clk_i) disable iff (!nrst_i)
      self_refresh_o |-> !dll_on_o && clk_gate_o;
   endproperty
   a_dll_entry: assert property (p_dll_entry) // R15
      else $error("dll left on in self-refresh");

   property p_timer_gap;
      @(posedge clk_i) disable iff (!nrst_i)
      gate_reg |-> gap_reg <= sdram_pkg::T_REFI_CYC + 8'h01;
   endproperty
   a_timer_gap: assert property (p_timer_gap) // R16
      else $error("self-refresh timer missed a refresh");

endmodule // sdram_cmd_core
`default_nettype wire

// ===== hw/sync3.sv
// three-stage synchroniser with agreement filter
// assumes d_i changes slowly against clk_i
`timescale 1ns/10ps
`default_nettype none
module sync3 #(
   parameter int W = 1
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] s1_reg, s2_reg, s3_reg, q_reg;
   logic [W-1:0] q_next;

   // a bit is taken only when the second and third stages agree
   for (genvar i = 0; i < W; i++) begin : g_bit
      always_comb begin
         q_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : q_reg[i];
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
         q_reg <= '0;
      end else begin
         s1_reg <= d_i;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         q_reg <= q_next;
      end
   end

   assign q_o = q_reg;
endmodule // sync3
`default_nettype wire

// ===== inc/sdram_pkg.sv
// constants, carrier types and state encodings of the dram command core
// assumes a 25 MHz internal clock and a command clock from the controller
//
// Behaviour
// [R1] a12 low on read or write means four-beat chop, high means eight beats
// [R2] broken strobe timing may corrupt that write only; device never hangs
// [R3] one mask bit per eight data bits, timed like data, ignored on reads
// [R4] controller issues each refresh as cs ras cas low, we high
// [R5] controller precharges all banks for the precharge time before refresh
// [R6] refresh rows come from an internal counter; banks end precharged idle
// [R7] controller sends only nop or deselect until refresh cycle time ends
// [R8] controller refreshes on average each interval, postponing at most eight
// [R9] up to eight refreshes may be pulled in; each is simply performed
// [R10] controller issues postponed refreshes before self-refresh entry
// [R11] self-refresh entry is the refresh pattern with cke registered low
// [R12] self-refresh entry only when idle with all banks precharged
// [R13] controller turns termination off before self-refresh entry
// [R14] device stays in self-refresh while cke stays low
// [R15] dll switches off on self-refresh entry, back on with reset at exit
// [R16] in self-refresh only cke and reset count; clock gated; own timer
// [R17] at least one internal refresh shortly after self-refresh entry
// [R18] controller may stop the clock only after entry, restarts before exit
// [R19] controller waits 512 clocks before first write after exit
// [R20] exit is cke rising with nop; controller waits exit delays
// [R21] cke stays high through the dll exit period except for re-entry
// [R22] controller keeps termination off during the dll exit period
// [R23] controller tracks refresh credit between minus eight and plus eight
package sdram_pkg;

   localparam int DQ_W = 16;
   localparam int DM_W = DQ_W / 8;
   localparam int ROW_W = 13;
   localparam int BEAT_W = 4;
   localparam int CNT_W = 8;

   localparam logic [BEAT_W-1:0] BURST_CHOP_BEATS = 4'h4;
   localparam logic [BEAT_W-1:0] BURST_FULL_BEATS = 4'h8;
   localparam logic [BEAT_W-1:0] BEAT_LAST = 4'h1;

   // timing: figures in ns, counts derived from the internal clock period
   localparam int CLK_NS = 40;
   localparam int T_RFC_NS = 110;
   localparam int T_REFI_NS = 7800;
   localparam logic [CNT_W-1:0] T_RFC_CYC =
      CNT_W'((T_RFC_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [CNT_W-1:0] T_REFI_CYC = CNT_W'(T_REFI_NS / CLK_NS);

   typedef struct packed {
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
   } cmd_pins_t;

   typedef struct packed {
      logic [DQ_W-1:0] data;
      logic [DM_W-1:0] mask;
   } beat_t;

   typedef enum logic [1:0] {
      L_IDLE = 2'b00,
      L_WRITE = 2'b01,
      L_READ = 2'b10,
      L_SELF = 2'b11
   } link_state_t;

   typedef enum logic [0:0] {
      S_NORMAL = 1'b0,
      S_SELF = 1'b1
   } sr_state_t;

endpackage

// ===== verification/ctrl_model.sv
// controller model: command clock, command pins, cke and write data
// assumes the bench calls its tasks one at a time
`timescale 1ns/10ps
`default_nettype none
module ctrl_model (
   output logic ck_o,
   output sdram_pkg::cmd_pins_t cmd_o,
   output logic cke_o,
   output logic a12_o,
   output logic [sdram_pkg::DQ_W-1:0] dq_o,
   output logic [sdram_pkg::DM_W-1:0] dm_o,
   output logic strobe_err_o
);
   localparam sdram_pkg::cmd_pins_t NOP = 4'h7;
   logic run;
   int credit = 0;

   // ----------------------------------------------------------------
   // command clock
   // ----------------------------------------------------------------
   // the offset keeps this clock unrelated in phase to the core clock
   initial begin
      ck_o = 1'b0;
      run = 1'b1;
      #7;
      forever begin
         #15;
         if (run) begin
            ck_o = ~ck_o;
         end
      end
   end

   initial begin
      cmd_o = 4'hf;
      cke_o = 1'b1;
      a12_o = 1'b0;
      dq_o = 16'h0;
      dm_o = 2'h0;
      strobe_err_o = 1'b0;
   end

   // refresh credit: one refresh falls due per interval while cke is high
   always begin
      #(sdram_pkg::T_REFI_NS);
      if (cke_o) begin
         credit--;
      end
   end

   // ----------------------------------------------------------------
   // bus tasks
   // ----------------------------------------------------------------
   task automatic edge_wait();
      @(posedge ck_o);
      #1;
   endtask

   // refresh is 4'h1 with cke high, self-refresh entry with cke low
   task automatic issue(input sdram_pkg::cmd_pins_t c, input logic cke,
                        input logic a12);
      @(negedge ck_o);
      cmd_o = c;
      cke_o = cke;
      a12_o = a12;
      if (c == 4'h1 && cke && credit < 8) begin
         credit++;
      end
      dq_o = ~dq_o;
      edge_wait();
   endtask

   task automatic beat(input logic [15:0] d, input logic [1:0] m,
                       input logic e);
      @(negedge ck_o);
      cmd_o = NOP;
      dq_o = d;
      dm_o = m;
      strobe_err_o = e;
      edge_wait();
   endtask

   // released data lines never keep showing the last beat
   task automatic idle(input int n);
      repeat (n) begin
         @(negedge ck_o);
         cmd_o = NOP;
         dq_o = ~dq_o;
         strobe_err_o = 1'b0;
      end
   endtask

   task automatic stop_clock();
      @(negedge ck_o);
      run = 1'b0;
   endtask

   task automatic start_clock();
      run = 1'b1;
   endtask
endmodule // ctrl_model
`default_nettype wire

// ===== verification/tb.sv
// self-checking bench of the dram command core
// assumes ctrl_model drives the command side; core clock made here
`timescale 1ns/10ps
`default_nettype none
module tb;
   localparam sdram_pkg::cmd_pins_t WR = 4'h4;
   localparam sdram_pkg::cmd_pins_t RD = 4'h5;
   localparam sdram_pkg::cmd_pins_t REF = 4'h1;
   localparam sdram_pkg::cmd_pins_t NOP = 4'h7;
   logic clk_i, nrst_i, dll_disable_i;
   wire logic ck, cke, a12, serr;
   wire sdram_pkg::cmd_pins_t cmd;
   wire logic [15:0] dq;
   wire logic [1:0] dm;
   sdram_pkg::beat_t beat_o;
   logic beat_valid_o, burst_chop_o, wr_corrupt_o, refresh_active_o;
   logic banks_idle_o, self_refresh_o, dll_on_o, dll_reset_o, clk_gate_o;
   logic [sdram_pkg::ROW_W-1:0] refresh_row_o, exp_row;
   int fail_count = 0;
   int check_count = 0;

   ctrl_model i_ctrl_model (.ck_o(ck), .cmd_o(cmd), .cke_o(cke),
      .a12_o(a12), .dq_o(dq), .dm_o(dm), .strobe_err_o(serr));
   sdram_cmd_core i_sdram_cmd_core (.clk_i(clk_i), .nrst_i(nrst_i),
      .ck_i(ck), .cmd_i(cmd), .cke_i(cke), .a12_i(a12), .dq_i(dq),
      .dm_i(dm), .strobe_err_i(serr), .dll_disable_i(dll_disable_i),
      .beat_o(beat_o), .beat_valid_o(beat_valid_o),
      .burst_chop_o(burst_chop_o), .wr_corrupt_o(wr_corrupt_o),
      .refresh_active_o(refresh_active_o), .refresh_row_o(refresh_row_o),
      .banks_idle_o(banks_idle_o), .self_refresh_o(self_refresh_o),
      .dll_on_o(dll_on_o), .dll_reset_o(dll_reset_o),
      .clk_gate_o(clk_gate_o));

   always #20 clk_i = ~clk_i;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // sel 0 watches refresh activity, sel 1 self-refresh state
   task automatic wait_lvl(input int sel, input logic lvl);
      for (int i = 0; i < 20; i++) begin
         @(posedge clk_i);
         #1;
         if ((sel == 0 ? refresh_active_o : self_refresh_o) === lvl) begin
            return;
         end
      end
      check(sel == 0 ? refresh_active_o : self_refresh_o, lvl);
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_write(input logic a12v, input int bad);
      int n;
      logic [15:0] d;
      logic seen;
      n = a12v ? 8 : 4;
      i_ctrl_model.issue(WR, 1'b1, a12v);
      for (int i = 0; i < n; i++) begin
         d = {4'(i), 12'h5a3} ^ {16{a12v}};
         i_ctrl_model.beat(d, 2'(i), i == bad);
         check(beat_o, {d, 2'(i)});
         check(beat_valid_o, 1'b1);
         if (i < n - 1) begin
            check(wr_corrupt_o, 1'b0);
         end
      end
      seen = wr_corrupt_o;
      i_ctrl_model.idle(1);
      @(posedge ck);
      #1;
      seen = seen | wr_corrupt_o;
      check(seen, bad >= 0);
      check(beat_valid_o, 1'b0);
      check(burst_chop_o, !a12v);
      $display("write test done, beats %0d", n);
   endtask

   task automatic t_read();
      i_ctrl_model.issue(RD, 1'b1, 1'b0);
      repeat (9) begin
         i_ctrl_model.beat(16'h0f0f, 2'h3, 1'b0);
         check(beat_valid_o, 1'b0);
      end
      check(burst_chop_o, 1'b1);
      i_ctrl_model.issue(RD, 1'b1, 1'b1);
      i_ctrl_model.idle(1);
      @(posedge ck);
      #1;
      check(burst_chop_o, 1'b0);
      $display("read test done");
   endtask

   // a12 high during refresh: the address bus must not matter
   task automatic t_refresh();
      int len;
      for (int k = 0; k < 2; k++) begin
         i_ctrl_model.issue(REF, 1'b1, 1'b1);
         i_ctrl_model.idle(1);
         wait_lvl(0, 1'b1);
         exp_row++;
         check(refresh_row_o, exp_row);
         check(banks_idle_o, 1'b0);
         len = 0;
         while (refresh_active_o === 1'b1 && len < 20) begin
            @(posedge clk_i);
            #1;
            len++;
         end
         check(len, sdram_pkg::T_RFC_CYC);
         check(banks_idle_o, 1'b1);
         i_ctrl_model.idle(2);
      end
      $display("refresh test done");
   endtask

   task automatic t_self(input logic dis);
      @(negedge clk_i);
      dll_disable_i = dis;
      @(posedge clk_i);
      #1;
      check(dll_on_o, !dis);
      // settle postponed refreshes before entry
      while (i_ctrl_model.credit < 0) begin
         i_ctrl_model.issue(REF, 1'b1, 1'b0);
         i_ctrl_model.idle(12);
         exp_row++;
      end
      i_ctrl_model.issue(REF, 1'b0, 1'b0);
      wait_lvl(1, 1'b1);
      check(clk_gate_o, 1'b1);
      check(dll_on_o, 1'b0);
      check(refresh_active_o, 1'b1);
      exp_row++;
      check(refresh_row_o, exp_row);
      i_ctrl_model.stop_clock();
      repeat (100) @(posedge clk_i);
      #1;
      check(self_refresh_o, 1'b1);
      i_ctrl_model.start_clock();
      i_ctrl_model.issue(WR, 1'b0, 1'b1);
      repeat (9) begin
         i_ctrl_model.beat(16'h3c3c, 2'h0, 1'b0);
         check(beat_valid_o, 1'b0);
      end
      // second internal refresh comes from the built-in timer
      repeat (120) @(posedge clk_i);
      #1;
      exp_row++;
      check(refresh_row_o, exp_row);
      i_ctrl_model.issue(NOP, 1'b1, 1'b0);
      wait_lvl(1, 1'b0);
      check(dll_reset_o, !dis);
      check(dll_on_o, !dis);
      check(clk_gate_o, 1'b0);
      @(posedge clk_i);
      #1;
      check(dll_reset_o, 1'b0);
      i_ctrl_model.idle(520);
      $display("self-refresh test done");
   endtask

   // ----------------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      nrst_i = 1'b0;
      dll_disable_i = 1'b0;
      exp_row = '0;
      repeat (4) @(posedge clk_i);
      @(negedge clk_i);
      nrst_i = 1'b1;
      @(posedge clk_i);
      #1;
      check(dll_on_o, 1'b1);
      check(refresh_row_o, 13'h0000);
      i_ctrl_model.idle(3);
      t_write(1'b0, -1);
      t_write(1'b1, 5);
      t_write(1'b0, 3);
      t_read();
      t_refresh();
      t_self(1'b0);
      t_write(1'b1, -1);
      t_self(1'b1);
      results();
   end

   // whole run is about 53 us; a hang counts as a mismatch
   initial begin
      #200000;
      fail_count++;
      results();
   end
endmodule // tb
`default_nettype wire
